// ### design/addr_tenure_pkg.sv
// Package: constants for the address tenure, snoop and parity block
package addr_tenure_pkg;
   localparam int ADDR_W = 32;
   localparam int PAR_W = 4;
   localparam int BYTE_W = 8;
   localparam int TAG_W = 4;
   // Receiver tag sits in bits 28..31 of the identifier (bit 0 is MSB)
   localparam int PID_TAG_LSB = 0;
   localparam int ERR_ASSERT_DLY = 2;
   localparam int ERR_FLOAT_DLY = 3;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [PAR_W-1:0] PAR_RST = 4'hF;
   localparam logic [TAG_W-1:0] TAG_RST = 4'h0;
   localparam logic [1:0] DLY_RST = 2'h0;
   // Receiver tag and reply flag positions within packet 0
   localparam int REPLY_TAG_LSB = 0;
   localparam int REPLY_FLAG_BIT = 31;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_MEM,
      OP_IO
   } op_kind_t;

   typedef enum {
      ST_IDLE,
      ST_MEM_START,
      ST_IO_BEAT0,
      ST_IO_BEAT1,
      ST_WAIT_ACK,
      ST_RELEASE
   } mst_state_t;

   // Odd parity per byte: bit i covers the i-th byte from the MSB end
   function automatic logic [PAR_W-1:0] odd_parity(input logic [ADDR_W-1:0] a);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int i = 0; i < PAR_W; i++) begin
         p[PAR_W-1-i] = ~(^a[i*BYTE_W +: BYTE_W]);
      end
      return p;
   endfunction : odd_parity
endpackage : addr_tenure_pkg

// ### design/addr_parity_check.sv
// Checks odd address parity on a snooped beat and times the error pin
`timescale 1ns/1ps
module addr_parity_check
   import addr_tenure_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample,
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] addr_in,
   input wire logic [addr_tenure_pkg::PAR_W-1:0] par_in,
   input wire logic check_en,
   output logic par_err_oe,
   output logic checkstop
);
   logic bad_d;
   logic bad_q;

   assign bad_d = sample && (odd_parity(addr_in) != par_in);

   // Strobe cycle is 0; this flop and the top stage put the pin in cycle 2
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_q <= 1'b0;
      end else begin
         bad_q <= bad_d;
      end
   end

   // One clock wide, so the pin floats again in cycle 3
   assign par_err_oe = bad_q;

   // Checkstop is sticky until reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         checkstop <= 1'b0;
      end else if (bad_q && check_en) begin
         checkstop <= 1'b1;
      end
   end
endmodule : addr_parity_check

// ### design/io_reply_match.sv
// Matches a snooped I/O reply tag against the processor identifier
`timescale 1ns/1ps
module io_reply_match
   import addr_tenure_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample,
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] addr_in,
   input wire logic [addr_tenure_pkg::TAG_W-1:0] proc_tag,
   output logic reply_hit
);
   logic is_reply;
   logic tag_eq;

   assign is_reply = addr_in[REPLY_FLAG_BIT];
   assign tag_eq = addr_in[REPLY_TAG_LSB +: TAG_W] == proc_tag;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reply_hit <= 1'b0;
      end else begin
         reply_hit <= sample && is_reply && tag_eq;
      end
   end
endmodule : io_reply_match

// ### design/addr_tenure.sv
// Address tenure master, snoop capture and address parity for the system bus
//
// Behaviour
// - An I/O operation mastered here asserts the extended start strobe on its first beat.
// - The extended start output stays negated for every memory transaction mastered here.
// - Extended start asserts with address busy, negates a clock later, floats when busy ends.
// - A sampled external extended start triggers a reply tag check against the identifier.
// - The 32 address lines are driven when master and sampled when snooping.
// - Memory operations drive the physical address, quad-word-aligned for bursts only.
// - Memory address drives after a qualified grant and floats a clock after acknowledge.
// - I/O operations use two packets: control and tag for one cycle, then data address held until acknowledge.
// - I/O beat 0 follows the grant, beat 1 the next clock, float after acknowledge.
// - When not master only the first I/O beat is snooped and checked; the second is ignored.
// - One odd parity bit per address byte, bit 0 covering the top byte.
// - Parity lines share the drive and float timing of the address lines.
// - Enabled checking enters checkstop on even parity of any snooped byte.
// - The parity error pin asserts two clocks after the strobe and floats in the third.
// - Address busy negates in the clock after acknowledge is asserted.
`timescale 1ns/1ps
module addr_tenure
   import addr_tenure_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // Request from the core
   input wire logic req_valid,
   input wire addr_tenure_pkg::op_kind_t req_kind,
   input wire logic req_burst,
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] req_addr,
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] req_ctrl,
   output logic req_ready,
   output logic tenure_done,
   // Configuration
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] proc_ident_reg,
   input wire logic checkstop_enable_reg,
   // Arbitration
   input wire logic bus_grant_n,
   input wire logic addr_bus_busy_n_in,
   output logic addr_bus_busy_n_out,
   output logic addr_bus_busy_n_oe,
   input wire logic addr_ack_n,
   input wire logic global_snoop_n,
   // Transfer starts
   input wire logic mem_xfer_start_n_in,
   output logic mem_xfer_start_n_out,
   output logic mem_xfer_start_n_oe,
   input wire logic ext_xfer_start_n_in,
   output logic ext_xfer_start_n_out,
   output logic ext_xfer_start_n_oe,
   // Address and parity
   input wire logic [addr_tenure_pkg::ADDR_W-1:0] addr_in,
   output logic [addr_tenure_pkg::ADDR_W-1:0] addr_out,
   output logic addr_oe,
   input wire logic [addr_tenure_pkg::PAR_W-1:0] addr_parity_in,
   output logic [addr_tenure_pkg::PAR_W-1:0] addr_parity_out,
   output logic addr_parity_oe,
   // Open-drain error pin: driven low while enabled
   output logic addr_parity_err_n_out,
   output logic addr_parity_err_n_oe,
   // Snoop results
   output logic snoop_valid,
   output logic [addr_tenure_pkg::ADDR_W-1:0] snoop_addr,
   output logic io_reply_hit,
   output logic checkstop
);
   localparam logic [ADDR_W-1:0] QUAD_MASK = 32'hFFFF_FFF0;

   // Burst starts on the quad-word holding the critical word
   function automatic logic [ADDR_W-1:0] burst_align(input logic [ADDR_W-1:0] a,
      input logic burst);
      return burst ? (a & QUAD_MASK) : a;
   endfunction : burst_align

   mst_state_t state_q;
   logic kind_io_q;
   logic [ADDR_W-1:0] addr_hold_q;
   logic qual_grant;
   logic ack_seen;
   logic snoop_mem;
   logic snoop_io;
   logic check_beat;
   logic par_err_oe;
   logic hit;
   logic stop;
   logic start_tenure;
   logic busy_ends;
   logic [ADDR_W-1:0] mem_addr;

   // Grant counts only while nobody else holds the bus and we are idle
   assign qual_grant = !bus_grant_n && addr_bus_busy_n_in && (state_q == ST_IDLE);
   assign ack_seen = !addr_ack_n;
   assign start_tenure = qual_grant && req_valid && (req_kind != OP_NONE);
   // Busy only negates for a tenure we are still driving
   assign busy_ends = ack_seen && addr_bus_busy_n_oe && !addr_bus_busy_n_out;
   assign mem_addr = burst_align(req_addr, req_burst);

   // Not master: memory snoops need global, I/O first beat always
   assign snoop_mem = !mem_xfer_start_n_in && !global_snoop_n && (state_q == ST_IDLE);
   assign snoop_io = !ext_xfer_start_n_in && (state_q == ST_IDLE);
   assign check_beat = snoop_mem || snoop_io;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (qual_grant && req_valid && req_kind == OP_MEM) begin
                  state_q <= ST_MEM_START;
               end else if (qual_grant && req_valid && req_kind == OP_IO) begin
                  state_q <= ST_IO_BEAT0;
               end
            end
            ST_MEM_START: begin
               if (ack_seen) begin
                  state_q <= ST_RELEASE;
               end else begin
                  state_q <= ST_WAIT_ACK;
               end
            end
            ST_IO_BEAT0: begin
               if (ack_seen) begin
                  state_q <= ST_RELEASE;
               end else begin
                  state_q <= ST_IO_BEAT1;
               end
            end
            ST_IO_BEAT1: begin
               if (ack_seen) begin
                  state_q <= ST_RELEASE;
               end else begin
                  state_q <= ST_WAIT_ACK;
               end
            end
            ST_WAIT_ACK: begin
               if (ack_seen) begin
                  state_q <= ST_RELEASE;
               end else begin
                  state_q <= ST_WAIT_ACK;
               end
            end
            ST_RELEASE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Operation kind and data address latched at grant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kind_io_q <= 1'b0;
         addr_hold_q <= ADDR_RST;
      end else if (qual_grant && req_valid) begin
         kind_io_q <= (req_kind == OP_IO);
         addr_hold_q <= mem_addr;
      end
   end

   // Address and parity drive; pins reflect the state one clock later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_out <= ADDR_RST;
         addr_oe <= 1'b0;
         addr_parity_out <= PAR_RST;
         addr_parity_oe <= 1'b0;
      end else begin
         if (qual_grant && req_valid) begin
            if (req_kind == OP_IO) begin
               addr_out <= req_ctrl;
               addr_parity_out <= odd_parity(req_ctrl);
            end else begin
               addr_out <= mem_addr;
               addr_parity_out <= odd_parity(mem_addr);
            end
            addr_oe <= (req_kind != OP_NONE);
            addr_parity_oe <= (req_kind != OP_NONE);
         end else if (state_q == ST_IO_BEAT0) begin
            addr_out <= addr_hold_q;
            addr_parity_out <= odd_parity(addr_hold_q);
            addr_oe <= !ack_seen;
            addr_parity_oe <= !ack_seen;
         end else if (ack_seen || state_q == ST_RELEASE) begin
            addr_oe <= 1'b0;
            addr_parity_oe <= 1'b0;
         end
      end
   end

   // Address busy: asserts with the first beat, negates after acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_bus_busy_n_out <= 1'b1;
         addr_bus_busy_n_oe <= 1'b0;
      end else if (start_tenure) begin
         addr_bus_busy_n_out <= 1'b0;
         addr_bus_busy_n_oe <= 1'b1;
      end else begin
         if (busy_ends) begin
            addr_bus_busy_n_out <= 1'b1;
         end
         if (state_q == ST_RELEASE) begin
            addr_bus_busy_n_oe <= 1'b0;
         end
      end
   end

   // Memory start: one clock wide, floated as busy negates
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_xfer_start_n_out <= 1'b1;
         mem_xfer_start_n_oe <= 1'b0;
      end else if (start_tenure) begin
         mem_xfer_start_n_out <= (req_kind != OP_MEM);
         mem_xfer_start_n_oe <= 1'b1;
      end else begin
         mem_xfer_start_n_out <= 1'b1;
         if (busy_ends || state_q == ST_RELEASE) begin
            mem_xfer_start_n_oe <= 1'b0;
         end
      end
   end

   // Extended start: negated through memory tenures, floated as busy negates
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_xfer_start_n_out <= 1'b1;
         ext_xfer_start_n_oe <= 1'b0;
      end else if (start_tenure) begin
         ext_xfer_start_n_out <= (req_kind != OP_IO);
         ext_xfer_start_n_oe <= 1'b1;
      end else begin
         ext_xfer_start_n_out <= 1'b1;
         if (busy_ends || state_q == ST_RELEASE) begin
            ext_xfer_start_n_oe <= 1'b0;
         end
      end
   end

   // Core handshake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
         tenure_done <= 1'b0;
      end else begin
         req_ready <= start_tenure;
         tenure_done <= (state_q != ST_IDLE) && (state_q != ST_RELEASE) && ack_seen;
      end
   end

   // Snoop capture of the first beat only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snoop_valid <= 1'b0;
         snoop_addr <= ADDR_RST;
      end else begin
         snoop_valid <= check_beat;
         if (check_beat) begin
            snoop_addr <= addr_in;
         end
      end
   end

   // Reply flag and tag positions in packet 0 are a local choice
   io_reply_match u_match (
      .clk(clk),
      .rst_n(rst_n),
      .sample(snoop_io),
      .addr_in(addr_in),
      .proc_tag(proc_ident_reg[PID_TAG_LSB +: TAG_W]),
      .reply_hit(hit)
   );

   addr_parity_check u_par (
      .clk(clk),
      .rst_n(rst_n),
      .sample(check_beat),
      .addr_in(addr_in),
      .par_in(addr_parity_in),
      .check_en(checkstop_enable_reg),
      .par_err_oe(par_err_oe),
      .checkstop(stop)
   );

   // Extra stage keeps outputs on flops; error pin lands in cycle 2
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_reply_hit <= 1'b0;
         checkstop <= 1'b0;
         addr_parity_err_n_out <= 1'b1;
         addr_parity_err_n_oe <= 1'b0;
      end else begin
         io_reply_hit <= hit;
         checkstop <= stop;
         addr_parity_err_n_out <= !par_err_oe;
         addr_parity_err_n_oe <= par_err_oe;
      end
   end
endmodule : addr_tenure

// ### sim/addr_tenure_chk.sv
// Port checker for the address tenure block
`timescale 1ns/1ps
module addr_tenure_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_ready,
   input wire logic bus_grant_n,
   input wire logic addr_ack_n,
   input wire logic addr_bus_busy_n_out,
   input wire logic addr_bus_busy_n_oe,
   input wire logic mem_xfer_start_n_in,
   input wire logic mem_xfer_start_n_out,
   input wire logic ext_xfer_start_n_in,
   input wire logic ext_xfer_start_n_out,
   input wire logic ext_xfer_start_n_oe,
   input wire logic [31:0] addr_out,
   input wire logic addr_oe,
   input wire logic [3:0] addr_parity_out,
   input wire logic addr_parity_oe,
   input wire logic addr_parity_err_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence io_beats;
      !ext_xfer_start_n_out ##1 ext_xfer_start_n_out && addr_oe;
   endsequence
   sequence err_pulse;
      addr_parity_err_n_oe ##1 !addr_parity_err_n_oe;
   endsequence
   ext_xfer_start_n_pulse_a: assert property ($fell(ext_xfer_start_n_out) |-> io_beats)
      else $error("ext start not one clock");
   ext_xfer_start_n_busy_a: assert property ($fell(ext_xfer_start_n_out) |->
      $fell(addr_bus_busy_n_out)) else $error("ext start without busy");
   ts_only_a: assert property ($fell(mem_xfer_start_n_out) |-> ext_xfer_start_n_out[*3])
      else $error("ext start in memory tenure");
   par_gen_a: assert property (addr_parity_oe |-> addr_parity_out ==
      ~{^addr_out[7:0], ^addr_out[15:8], ^addr_out[23:16], ^addr_out[31:24]})
      else $error("bad address parity");
   par_oe_a: assert property (addr_parity_oe == addr_oe)
      else $error("parity and address enables differ");
   busy_end_a: assert property (!addr_bus_busy_n_out && addr_bus_busy_n_oe && !addr_ack_n
      |=> addr_bus_busy_n_out) else $error("busy held after ack");
   addr_float_a: assert property (addr_oe && !addr_ack_n |=> !addr_oe
      ##1 !(addr_bus_busy_n_oe || ext_xfer_start_n_oe)) else $error("bus not released");
   grant_take_a: assert property (req_ready |-> $past(!bus_grant_n) && addr_oe
      && !addr_bus_busy_n_out && mem_xfer_start_n_out != ext_xfer_start_n_out)
      else $error("tenure start without grant");
   err_time_a: assert property ($rose(addr_parity_err_n_oe) |->
      $past(!mem_xfer_start_n_in || !ext_xfer_start_n_in, 2) ##0 err_pulse)
      else $error("parity error pin mistimed");
   ext_xfer_start_n_float_a: assert property ($rose(addr_bus_busy_n_out) |-> !ext_xfer_start_n_oe)
      else $error("ext start driven after busy negated");
endmodule : addr_tenure_chk

bind addr_tenure addr_tenure_chk chk (.clk, .rst_n, .req_ready, .bus_grant_n, .addr_ack_n,
   .addr_bus_busy_n_out, .addr_bus_busy_n_oe, .mem_xfer_start_n_in, .mem_xfer_start_n_out,
   .ext_xfer_start_n_in, .ext_xfer_start_n_out, .ext_xfer_start_n_oe, .addr_out, .addr_oe,
   .addr_parity_out, .addr_parity_oe, .addr_parity_err_n_oe);

// ### sim/bus_partner.sv
// Arbiter and memory controller model: parked grant, delayed acknowledge
`timescale 1ns/1ps
module bus_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic busy_n,
   input wire logic [2:0] ack_dly,
   output logic bus_grant_n,
   output logic addr_ack_n
);
   logic [2:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
         bus_grant_n <= 1'h1;
         addr_ack_n <= 1'h1;
      end else begin
         bus_grant_n <= 1'h0;
         cnt_q <= busy_n ? 3'h0 : cnt_q + 3'h1;
         // Delay of two or more keeps the ack off the second beat
         addr_ack_n <= !(!busy_n && cnt_q == ack_dly - 3'h1);
      end
   end
endmodule : bus_partner

// ### sim/bus_address_tenure_parity_tb.sv
// Bench: master tenures, refused grant, snoops and parity errors
`timescale 1ns/1ps
module bus_address_tenure_parity_tb;
   import addr_tenure_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_burst = 1'h0, seen = 1'h0;
   logic checkstop_enable_reg = 1'h0, global_snoop_n = 1'h1, cs_exp = 1'h0, om_oe = 1'h0;
   logic om_busy_n = 1'h1, om_ts_n = 1'h1, om_ext_xfer_start_n_n = 1'h1;
   op_kind_t req_kind = OP_MEM;
   logic [31:0] req_addr = 32'h0, req_ctrl = 32'h0, proc_ident_reg = 32'h0, om_addr = 32'h0, v;
   logic [3:0] om_par = 4'h0;
   logic [2:0] dly = 3'h2;
   integer seed = 96190, mismatches = 0, n_checks = 0;
   logic bus_grant_n, addr_ack_n, req_ready, tenure_done, addr_bus_busy_n_out, addr_oe;
   logic addr_bus_busy_n_oe, mem_xfer_start_n_out, mem_xfer_start_n_oe, ext_xfer_start_n_out;
   logic ext_xfer_start_n_oe, addr_parity_oe, addr_parity_err_n_out, addr_parity_err_n_oe;
   logic snoop_valid, io_reply_hit, checkstop;
   logic [31:0] addr_out, snoop_addr;
   logic [3:0] addr_parity_out;
   wire logic addr_bus_busy_n_in = om_busy_n & (addr_bus_busy_n_oe ? addr_bus_busy_n_out : 1'h1);
   wire logic mem_xfer_start_n_in = om_ts_n & (mem_xfer_start_n_oe ? mem_xfer_start_n_out : 1'h1);
   wire logic ext_xfer_start_n_in = om_ext_xfer_start_n_n & (ext_xfer_start_n_oe ? ext_xfer_start_n_out : 1'h1);
   // Undriven bus shows the inverse of the last value, never a stale copy
   wire logic [31:0] addr_in = addr_oe ? addr_out : om_oe ? om_addr : ~addr_out;
   wire logic [3:0] addr_parity_in = addr_parity_oe ? addr_parity_out :
      om_oe ? om_par : ~addr_parity_out;

   addr_tenure dut (.clk, .rst_n, .req_valid, .req_kind, .req_burst, .req_addr, .req_ctrl,
      .req_ready, .tenure_done, .proc_ident_reg, .checkstop_enable_reg, .bus_grant_n,
      .addr_bus_busy_n_in, .addr_bus_busy_n_out, .addr_bus_busy_n_oe, .addr_ack_n,
      .global_snoop_n, .mem_xfer_start_n_in, .mem_xfer_start_n_out, .mem_xfer_start_n_oe,
      .ext_xfer_start_n_in, .ext_xfer_start_n_out, .ext_xfer_start_n_oe, .addr_in, .addr_out,
      .addr_oe, .addr_parity_in, .addr_parity_out, .addr_parity_oe, .addr_parity_err_n_out,
      .addr_parity_err_n_oe, .snoop_valid, .snoop_addr, .io_reply_hit, .checkstop);
   bus_partner model (.clk, .rst_n, .busy_n(addr_bus_busy_n_in), .ack_dly(dly), .bus_grant_n,
      .addr_ack_n);

   always #20 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   function automatic logic [3:0] par(input logic [31:0] a);
      // Bit 0 covers the top byte
      return ~{^a[7:0], ^a[15:8], ^a[23:16], ^a[31:24]};
   endfunction : par

   task automatic master(input logic io, input logic [31:0] a, c, input logic bst);
      logic [31:0] ea;
      ea = bst ? {a[31:4], 4'h0} : a;
      @(negedge clk);
      req_kind = io ? OP_IO : OP_MEM;
      req_burst = bst;
      req_addr = a;
      req_ctrl = c;
      req_valid = 1'h1;
      for (int n = 0; n < 8 && req_ready !== 1'h1; n++)
         @(negedge clk);
      req_valid = 1'h0;
      chk(req_ready, 1);
      chk(addr_out, io ? c : ea);
      chk({ext_xfer_start_n_out, mem_xfer_start_n_out}, io ? 1 : 2);
      @(negedge clk);
      chk(addr_out, ea);
      for (int n = 0; n < 8 && tenure_done !== 1'h1; n++)
         @(negedge clk);
      chk(tenure_done, 1);
      repeat (2) @(negedge clk);
      chk({addr_oe, addr_bus_busy_n_oe, ext_xfer_start_n_oe, mem_xfer_start_n_oe,
         addr_parity_oe}, 0);
   endtask : master

   task automatic snoop(input logic io, input logic [31:0] a, input logic bad);
      @(negedge clk);
      om_oe = 1'h1;
      om_busy_n = 1'h0;
      om_addr = a;
      om_par = par(a) ^ {3'h0, bad};
      om_ts_n = io;
      om_ext_xfer_start_n_n = !io;
      global_snoop_n = 1'h0;
      @(negedge clk);
      om_ts_n = 1'h1;
      om_ext_xfer_start_n_n = 1'h1;
      global_snoop_n = 1'h1;
      om_addr = ~a;
      // Second beat carries bad parity; it must go unchecked
      om_par = par(~a) ^ 4'h8;
      chk(snoop_valid, 1);
      chk(snoop_addr, a);
      seen = io_reply_hit;
      @(negedge clk);
      om_oe = 1'h0;
      om_busy_n = 1'h1;
      seen |= io_reply_hit;
      chk(addr_parity_err_n_oe & !addr_parity_err_n_out, bad);
      @(negedge clk);
      seen |= io_reply_hit;
      chk(addr_parity_err_n_oe, 0);
      chk(seen, io && a[31] && a[3:0] === proc_ident_reg[3:0]);
      repeat (2) @(negedge clk);
      cs_exp |= bad & checkstop_enable_reg;
      chk(checkstop, cs_exp);
   endtask : snoop

   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      chk({addr_oe, addr_bus_busy_n_oe, ext_xfer_start_n_oe, addr_parity_oe, checkstop}, 0);
      proc_ident_reg = $random(seed);
      om_busy_n = 1'h0;
      req_valid = 1'h1;
      repeat (4) begin
         @(negedge clk);
         seen |= req_ready;
      end
      chk(seen, 0);
      // Free bus but no operation kind: still no tenure
      om_busy_n = 1'h1;
      req_kind = OP_NONE;
      repeat (3) begin
         @(negedge clk);
         seen |= req_ready | addr_oe | !addr_bus_busy_n_out;
      end
      chk(seen, 0);
      req_valid = 1'h0;
      for (int i = 0; i < 12; i++) begin
         dly = 3'(2 + {$random(seed)} % 4);
         master(i[0], $random(seed), $random(seed), i[1] & ~i[0]);
      end
      for (int i = 0; i < 16; i++) begin
         checkstop_enable_reg = i[3];
         v = $random(seed);
         if (i[2])
            v = {1'h1, v[30:4], proc_ident_reg[3:0]};
         snoop(i[0], v, i[1]);
      end
      final_report();
   end

   // Tests need about 230 cycles; allow 600
   initial begin
      #24000;
      mismatches++;
      final_report();
   end
endmodule : bus_address_tenure_parity_tb
